// [core/lips_regs.svh]
// Purpose: Offsets, fields, reset values and codes of the local interrupt unit
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data
// Notes: Definitions only
`ifndef LIPS_REGS_SVH
`define LIPS_REGS_SVH

`define LIPS_OFF_ACQUIRE 8'h00
`define LIPS_OFF_EOS 8'h04
`define LIPS_OFF_TPM 8'h08
`define LIPS_OFF_CTRL 8'h0c
`define LIPS_OFF_BASE 8'h10
`define LIPS_OFF_PIN0 8'h14
`define LIPS_OFF_PIN1 8'h18
`define LIPS_OFF_SRCVEC 8'h1c
`define LIPS_OFF_FWPEND 8'h20
`define LIPS_OFF_XCPU 8'h24
`define LIPS_OFF_CPUID 8'h28
`define LIPS_OFF_STATUS 8'h2c
`define LIPS_OFF_ENTRY 8'h30

`define LIPS_CTRL_EXT_EN 0
`define LIPS_CTRL_COLL_EN 1
`define LIPS_CTRL_MC_MASK 2
`define LIPS_TPM_MMI 16
`define LIPS_PIN_LEVEL 8
`define LIPS_FW_WARM 16

`define LIPS_CPUID_RST 8'h00
`define LIPS_SPURIOUS 8'h0f
`define LIPS_VEC_NMI 8'h02
`define LIPS_VEC_LEGACY 8'h00
`define LIPS_FIRST_GEN 8'h10
`define LIPS_WIDE_ENTRIES 7'd20
`define LIPS_ALL_ENTRIES 7'd68
`define LIPS_RSVD_ENTRY 7'd28
`define LIPS_NARROW_BASE 15'h5000
`define LIPS_EXT_ENTRY 7'd12
`define LIPS_RESP_OKAY 2'b00
`define LIPS_RESP_SLVERR 2'b10

`endif

// [core/lips_pkg.sv]
// Purpose: Types of the local interrupt unit
// Assumes: Nothing beyond the header of constants
// Notes: Whole state is one packed struct
package lips_pkg;

    typedef enum logic [1:0] {LIPS_CLS_EXT, LIPS_CLS_PMI, LIPS_CLS_WARM} lips_class_t;

    typedef struct packed {
        logic [255:0] pend;
        logic [255:0] insvc;
        logic [15:0] pmi_pend;
        logic warm_pend;
        logic [1:0] local_irq_pin_prev;
        logic pmi_prev;
        logic warm_prev;
        logic ext_en;
        logic coll_en;
        logic mc_mask;
        logic mmi;
        logic [3:0] mic;
        logic [16:0] base_hi;
        logic [1:0][10:0] pin_cfg;
        logic [23:0] src_vec;
        logic [7:0] cpu_id;
        logic [6:0] entry_idx;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic xcpu_valid;
        logic [7:0] xcpu_target;
        logic [7:0] xcpu_vector;
        logic take_valid;
        lips_class_t take_class;
        logic [7:0] take_vector;
        logic [31:0] take_entry;
    } lips_state_t;

endpackage : lips_pkg

// [core/lips_core.sv]
// Purpose: Pending, in-service and delivery logic of the local interrupt unit
// Assumes: All inputs synchronous to aclk; event inputs are one-cycle pulses
// Notes: Registers over AXI4-Lite; every output comes from the state register
//
// Operation
// - Handler table sits at the programmed base and spans 32KB.
// - First 20 entries are 64 bundles of 16 bytes each.
// - Next 48 entries are 16 bundles each, after the wide ones.
// - Reset, abort, warm-restart and management go to firmware, never the table.
// - Entry at offset 0x5800 is never a vectoring target.
// - Each local pin selects edge or level and its interrupt class.
// - A pin producing external interrupts always gives its programmed vector.
// - Pins for management or warm-restart classes behave as edge only.
// - Management pin assertion pends management vector 0.
// - Timer, monitor and corrected-check events pend their own programmed vectors.
// - Cross-processor messages name exactly one target, self allowed, no broadcast.
// - Bus messages are taken only when they carry our processor number.
// - Edge interrupts pend until acquired; level ones only while pin asserted.
// - Warm-restart and management pend until firmware clears; no in-service state.
// - One warm-restart bit, one bit per vector; repeats merge.
// - Enabled and unmasked highest pending interrupt is taken to its handler.
// - Acquire read clears returned vector's pending bit and sets in-service.
// - Any end-of-service write clears the highest in-service vector.
// - Warm-restart needs mask bit 0, management collection 1, external enable 1.
// - Warm-restart over management over external; vector number within classes.
// - Vector 2 over vector 0 over 16..255, higher number higher.
// - Vectors 16..255 form classes 1..15 of sixteen for mask compare.
// - Acquire returns 15 when nothing pending, the best is masked, or the best is not above the highest in-service.
module lips_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic msg_valid,
    input wire logic [7:0] msg_cpu_id,
    input wire logic [1:0] msg_class,
    input wire logic [7:0] msg_vector,
    input wire logic [1:0] local_irq_pin,
    input wire logic platform_mgmt_irq,
    input wire logic warm_restart_pin,
    input wire logic timer_evt,
    input wire logic perfmon_evt,
    input wire logic cmc_evt,
    output logic cross_cpu_irq_valid,
    output logic [7:0] cross_cpu_irq_target,
    output logic [7:0] cross_cpu_irq_vector,
    output logic take_valid,
    output logic [1:0] take_class,
    output logic [7:0] take_vector,
    output logic [31:0] take_entry
);

`include "lips_regs.svh"

    lips_pkg::lips_state_t s;
    lips_pkg::lips_state_t next_s;
    logic [8:0] hp_rank;
    logic [7:0] hp_vec;
    logic [8:0] hs_rank;
    logic [7:0] hs_vec;
    logic ext_ok;
    logic [3:0] pmi_vec;
    logic [31:0] wr_val;
    logic [15:0] ent;
    logic [10:0] cfg;
    logic lvl;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [8:0] lips_rank(input logic [7:0] v);
        // Vector ranking
        // nmi above legacy
        if (v == `LIPS_VEC_NMI)
            return 9'h101;
        if (v == `LIPS_VEC_LEGACY)
            return 9'h100;
        if (v >= `LIPS_FIRST_GEN)
            return {1'b0, v};
        return 9'h000;
    endfunction : lips_rank

    function automatic logic [15:0] lips_entry(input logic [6:0] idx);
        logic [6:0] rel;
        rel = idx - `LIPS_WIDE_ENTRIES;
        if (idx < `LIPS_WIDE_ENTRIES)
            return {1'b1, idx[4:0], 10'h000};
        if (idx == `LIPS_RSVD_ENTRY || idx >= `LIPS_ALL_ENTRIES)
            return 16'h0000;
        return {1'b1, `LIPS_NARROW_BASE + {rel, 8'h00}};
    endfunction : lips_entry

    function automatic logic [31:0] lips_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction : lips_merge

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_s = s;
        hp_rank = 9'h000;
        hp_vec = `LIPS_SPURIOUS;
        hs_rank = 9'h000;
        hs_vec = `LIPS_SPURIOUS;
        pmi_vec = 4'h0;
        wr_val = 32'h0000_0000;
        ent = 16'h0000;
        cfg = 11'h000;
        lvl = 1'b0;

        for (int i = 0; i < 256; i++)
        begin
            if (s.pend[i] && lips_rank(8'(i)) > hp_rank)
            begin
                hp_rank = lips_rank(8'(i));
                hp_vec = 8'(i);
            end
            if (s.insvc[i] && lips_rank(8'(i)) > hs_rank)
            begin
                hs_rank = lips_rank(8'(i));
                hs_vec = 8'(i);
            end
        end
        for (int p = 0; p < 16; p++)
        begin
            if (s.pmi_pend[p])
                pmi_vec = 4'(p);
        end

        ext_ok = (hp_rank != 9'h000) && (hp_rank > hs_rank)
                 && !(s.mmi && hp_vec != `LIPS_VEC_NMI)
                 && !(hp_vec >= `LIPS_FIRST_GEN && hp_vec[7:4] <= s.mic);

        // Delivery toward the core
        next_s.take_valid = 1'b1;
        next_s.take_entry = 32'h0000_0000;
        if (s.warm_pend && !s.mc_mask)
        begin
            next_s.take_class = lips_pkg::LIPS_CLS_WARM;
            next_s.take_vector = 8'h00;
        end
        else if (s.pmi_pend != 16'h0000 && s.coll_en)
        begin
            next_s.take_class = lips_pkg::LIPS_CLS_PMI;
            next_s.take_vector = {4'h0, pmi_vec};
        end
        else if (ext_ok && s.ext_en)
        begin
            next_s.take_class = lips_pkg::LIPS_CLS_EXT;
            next_s.take_vector = hp_vec;
            ent = lips_entry(`LIPS_EXT_ENTRY);
            next_s.take_entry = {s.base_hi, ent[14:0]};
        end
        else
        begin
            next_s.take_valid = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Write channel

        next_s.xcpu_valid = 1'b0;
        if (s.awready && s_axi_awvalid)
        begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid)
        begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s.aw_got && s.w_got)
        begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = `LIPS_RESP_OKAY;
            if (s.awaddr == `LIPS_OFF_EOS)
            begin
                if (hs_rank != 9'h000)
                    next_s.insvc[hs_vec] = 1'b0;
            end
            else if (s.awaddr == `LIPS_OFF_TPM)
            begin
                wr_val = lips_merge({15'h0, s.mmi, 12'h0, s.mic}, s.wdata, s.wstrb);
                next_s.mic = wr_val[3:0];
                next_s.mmi = wr_val[`LIPS_TPM_MMI];
            end
            else if (s.awaddr == `LIPS_OFF_CTRL)
            begin
                wr_val = lips_merge({29'h0, s.mc_mask, s.coll_en, s.ext_en}, s.wdata, s.wstrb);
                next_s.ext_en = wr_val[`LIPS_CTRL_EXT_EN];
                next_s.coll_en = wr_val[`LIPS_CTRL_COLL_EN];
                next_s.mc_mask = wr_val[`LIPS_CTRL_MC_MASK];
            end
            else if (s.awaddr == `LIPS_OFF_BASE)
            begin
                wr_val = lips_merge({s.base_hi, 15'h0}, s.wdata, s.wstrb);
                next_s.base_hi = wr_val[31:15];
            end
            else if (s.awaddr == `LIPS_OFF_PIN0 || s.awaddr == `LIPS_OFF_PIN1)
            begin
                wr_val = lips_merge({21'h0, s.pin_cfg[s.awaddr[3]]}, s.wdata, s.wstrb);
                next_s.pin_cfg[s.awaddr[3]] = wr_val[10:0];
            end
            else if (s.awaddr == `LIPS_OFF_SRCVEC)
            begin
                wr_val = lips_merge({8'h0, s.src_vec}, s.wdata, s.wstrb);
                next_s.src_vec = wr_val[23:0];
            end
            else if (s.awaddr == `LIPS_OFF_FWPEND)
            begin
                wr_val = s.wdata & {{8{s.wstrb[3]}}, {8{s.wstrb[2]}},
                                    {8{s.wstrb[1]}}, {8{s.wstrb[0]}}};
                next_s.pmi_pend = s.pmi_pend & ~wr_val[15:0];
                if (wr_val[`LIPS_FW_WARM])
                    next_s.warm_pend = 1'b0;
            end
            else if (s.awaddr == `LIPS_OFF_XCPU)
            begin
                next_s.xcpu_valid = 1'b1;
                next_s.xcpu_vector = s.wdata[7:0];
                next_s.xcpu_target = s.wdata[15:8];
            end
            else if (s.awaddr == `LIPS_OFF_CPUID)
            begin
                wr_val = lips_merge({24'h0, s.cpu_id}, s.wdata, s.wstrb);
                next_s.cpu_id = wr_val[7:0];
            end
            else if (s.awaddr == `LIPS_OFF_ENTRY)
            begin
                wr_val = lips_merge({25'h0, s.entry_idx}, s.wdata, s.wstrb);
                next_s.entry_idx = wr_val[6:0];
            end
            else
            begin
                next_s.bresp = `LIPS_RESP_SLVERR;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Read channel

        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
        if (s.arready && s_axi_arvalid)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `LIPS_RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (s_axi_araddr == `LIPS_OFF_ACQUIRE)
            begin
                if (ext_ok)
                begin
                    next_s.rdata = {24'h0, hp_vec};
                    next_s.pend[hp_vec] = 1'b0;
                    next_s.insvc[hp_vec] = 1'b1;
                end
                else
                begin
                    next_s.rdata = {24'h0, `LIPS_SPURIOUS};
                end
            end
            else if (s_axi_araddr == `LIPS_OFF_EOS || s_axi_araddr == `LIPS_OFF_XCPU)
                next_s.rdata = 32'h0000_0000;
            else if (s_axi_araddr == `LIPS_OFF_TPM)
                next_s.rdata = {15'h0, s.mmi, 12'h0, s.mic};
            else if (s_axi_araddr == `LIPS_OFF_CTRL)
                next_s.rdata = {29'h0, s.mc_mask, s.coll_en, s.ext_en};
            else if (s_axi_araddr == `LIPS_OFF_BASE)
                next_s.rdata = {s.base_hi, 15'h0};
            else if (s_axi_araddr == `LIPS_OFF_PIN0 || s_axi_araddr == `LIPS_OFF_PIN1)
                next_s.rdata = {21'h0, s.pin_cfg[s_axi_araddr[3]]};
            else if (s_axi_araddr == `LIPS_OFF_SRCVEC)
                next_s.rdata = {8'h0, s.src_vec};
            else if (s_axi_araddr == `LIPS_OFF_FWPEND)
                next_s.rdata = {15'h0, s.warm_pend, s.pmi_pend};
            else if (s_axi_araddr == `LIPS_OFF_CPUID)
                next_s.rdata = {24'h0, s.cpu_id};
            else if (s_axi_araddr == `LIPS_OFF_STATUS)
                next_s.rdata = {7'h0, ext_ok, hs_vec, 8'h0, hp_vec};
            else if (s_axi_araddr == `LIPS_OFF_ENTRY)
            begin
                ent = lips_entry(s.entry_idx);
                next_s.rdata = ent[15] ? {s.base_hi, ent[14:0]} : 32'h0000_0000;
            end
            else
                next_s.rresp = `LIPS_RESP_SLVERR;
        end

        ////////////////////////////////////////////////////////////////////////
        // Arrivals; sets come after clears so a same-cycle event is kept

        for (int k = 0; k < 2; k++)
        begin
            cfg = s.pin_cfg[k];
            lvl = cfg[`LIPS_PIN_LEVEL] && cfg[10:9] == 2'(lips_pkg::LIPS_CLS_EXT);
            if (lvl && !local_irq_pin[k] && s.local_irq_pin_prev[k])
                next_s.pend[cfg[7:0]] = 1'b0;
        end
        if (msg_valid && msg_cpu_id == s.cpu_id)
        begin
            if (msg_class == 2'(lips_pkg::LIPS_CLS_EXT))
                next_s.pend[msg_vector] = 1'b1;
            else if (msg_class == 2'(lips_pkg::LIPS_CLS_PMI))
                next_s.pmi_pend[msg_vector[3:0]] = 1'b1;
            else if (msg_class == 2'(lips_pkg::LIPS_CLS_WARM))
                next_s.warm_pend = 1'b1;
        end
        if (timer_evt)
            next_s.pend[s.src_vec[7:0]] = 1'b1;
        if (perfmon_evt)
            next_s.pend[s.src_vec[15:8]] = 1'b1;
        if (cmc_evt)
            next_s.pend[s.src_vec[23:16]] = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            cfg = s.pin_cfg[k];
            lvl = cfg[`LIPS_PIN_LEVEL] && cfg[10:9] == 2'(lips_pkg::LIPS_CLS_EXT);
            if (local_irq_pin[k] && (lvl || !s.local_irq_pin_prev[k]))
            begin
                if (cfg[10:9] == 2'(lips_pkg::LIPS_CLS_EXT))
                    next_s.pend[cfg[7:0]] = 1'b1;
                else if (cfg[10:9] == 2'(lips_pkg::LIPS_CLS_PMI))
                    next_s.pmi_pend[cfg[3:0]] = 1'b1;
                else if (cfg[10:9] == 2'(lips_pkg::LIPS_CLS_WARM))
                    next_s.warm_pend = 1'b1;
            end
        end
        if (platform_mgmt_irq && !s.pmi_prev)
            next_s.pmi_pend[0] = 1'b1;
        if (warm_restart_pin && !s.warm_prev)
            next_s.warm_pend = 1'b1;
        next_s.local_irq_pin_prev = local_irq_pin;
        next_s.pmi_prev = platform_mgmt_irq;
        next_s.warm_prev = warm_restart_pin;

        next_s.awready = !next_s.aw_got && !next_s.bvalid;
        next_s.wready = !next_s.w_got && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.mc_mask <= 1'b1;
            s.cpu_id <= `LIPS_CPUID_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign cross_cpu_irq_valid = s.xcpu_valid;
    assign cross_cpu_irq_target = s.xcpu_target;
    assign cross_cpu_irq_vector = s.xcpu_vector;
    assign take_valid = s.take_valid;
    assign take_class = s.take_class;
    assign take_vector = s.take_vector;
    assign take_entry = s.take_entry;

endmodule : lips_core

// [tb/lips_asserts.sv]
// Purpose: Port checks of the local interrupt unit
// Assumes: Bound to lips_core, one clock domain
// Notes: Acquire reads tracked by a helper flag
module lips_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic cross_cpu_irq_valid,
    input wire logic take_valid,
    input wire logic [1:0] take_class,
    input wire logic [7:0] take_vector,
    input wire logic [31:0] take_entry
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic acq_q;
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            acq_q <= (s_axi_araddr == 8'h00);
        end
    end
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
        else $error("read answer late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    acq_vec_a: assert property (s_axi_rvalid && acq_q |->
        s_axi_rdata[7:4] != 4'h0 || s_axi_rdata[7:0] inside {8'h00, 8'h02, 8'h0f})
        else $error("acquire gave reserved vector");
    xcpu_pulse_a: assert property (cross_cpu_irq_valid |=> !cross_cpu_irq_valid)
        else $error("cross message repeated");
    entry_ext_a: assert property (take_valid && take_class == 2'd0 |->
        take_entry[14:0] == 15'h3000) else $error("external entry wrong");
    entry_fw_a: assert property (take_valid && take_class != 2'd0 |->
        take_entry == 32'h0) else $error("firmware class used table");
    entry_rsvd_a: assert property (take_entry[14:0] != 15'h5800)
        else $error("reserved entry used");
    warm_vec_a: assert property (take_valid && take_class == 2'd2 |->
        take_vector == 8'h00) else $error("warm vector not zero");
endmodule : lips_asserts

bind lips_core lips_asserts lips_asserts_inst (.*);

// [tb/lips_peer.sv]
// Purpose: Bus interrupt message source
// Assumes: Tasks called just after a rising edge
// Notes: Idle lines show the inverse of the last message
module lips_peer (
    input wire logic aclk,
    output logic msg_valid,
    output logic [7:0] msg_cpu_id,
    output logic [1:0] msg_class,
    output logic [7:0] msg_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        msg_valid = 1'b0;
        msg_cpu_id = 8'hff;
        msg_class = 2'd3;
        msg_vector = 8'hff;
    end
    task automatic send(input logic [7:0] cpu, input logic [1:0] cls, input logic [7:0] vec);
        msg_valid <= 1'b1;
        msg_cpu_id <= cpu;
        msg_class <= cls;
        msg_vector <= vec;
        @(posedge aclk);
        msg_valid <= 1'b0;
        msg_cpu_id <= ~cpu;
        msg_class <= ~cls;
        msg_vector <= ~vec;
        @(posedge aclk);
    endtask : send
endmodule : lips_peer

// [tb/testbench.sv]
// Purpose: Self-checking bench of the local interrupt unit
// Assumes: Register access over AXI4-Lite
// Notes: Messages come from the peer model
`include "lips_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, msg_cpu_id, msg_vector, take_vector;
    logic [7:0] cross_cpu_irq_target, cross_cpu_irq_vector;
    logic [31:0] s_axi_wdata, s_axi_rdata, take_entry, rd_val;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, msg_class, local_irq_pin, take_class, last_resp;
    logic msg_valid, platform_mgmt_irq, warm_restart_pin, timer_evt, perfmon_evt, cmc_evt;
    logic cross_cpu_irq_valid, take_valid;
    logic [31:0] eidx [5] = '{32'd19, 32'd20, 32'd28, 32'd67, 32'd68};
    logic [31:0] eexp [5] = '{32'h1cc00, 32'h1d000, 32'h0, 32'h1ff00, 32'h0};
    int error_cnt = 0;
    int comparisons = 0;
    lips_core lips_core_inst (.*);
    lips_peer lips_peer_inst (.*);
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid)
            begin
                last_resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid)
            begin
                d = s_axi_rdata;
                last_resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end while (s_axi_arvalid || s_axi_rready);
    endtask : rd
    task automatic acq(input logic [7:0] e);
        rd(`LIPS_OFF_ACQUIRE, rd_val);
        chk("acquire", 32'(e), 32'(rd_val[7:0]));
    endtask : acq
    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask : settle
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, local_irq_pin} = '0;
        {platform_mgmt_irq, warm_restart_pin, timer_evt, perfmon_evt, cmc_evt} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(`LIPS_OFF_CTRL, rd_val);
        chk("ctrl", 32'h4, rd_val);
        acq(8'h0f);
        wr(8'h3c, 32'h1);
        chk("bresp", 32'(`LIPS_RESP_SLVERR), 32'(last_resp));
        rd(8'h3c, rd_val);
        chk("rresp", 32'(`LIPS_RESP_SLVERR), 32'(last_resp));
        wr(`LIPS_OFF_CPUID, 32'h5);
        lips_peer_inst.send(8'h06, 2'd0, 8'h60);
        lips_peer_inst.send(8'h05, 2'd0, 8'h40);
        lips_peer_inst.send(8'h05, 2'd0, 8'h40);
        lips_peer_inst.send(8'h05, 2'd0, 8'h80);
        lips_peer_inst.send(8'h05, 2'd0, 8'h02);
        acq(8'h02);
        acq(8'h0f);
        wr(`LIPS_OFF_EOS, 32'h0);
        acq(8'h80);
        wr(`LIPS_OFF_EOS, 32'h0);
        acq(8'h40);
        wr(`LIPS_OFF_EOS, 32'h0);
        acq(8'h0f);
        wr(`LIPS_OFF_TPM, 32'h4);
        lips_peer_inst.send(8'h05, 2'd0, 8'h45);
        acq(8'h0f);
        wr(`LIPS_OFF_TPM, 32'h3);
        acq(8'h45);
        wr(`LIPS_OFF_EOS, 32'h0);
        wr(`LIPS_OFF_BASE, 32'h18000);
        wr(`LIPS_OFF_CTRL, 32'h1);
        lips_peer_inst.send(8'h05, 2'd0, 8'h90);
        settle();
        chk("take", 32'h1, 32'(take_valid));
        chk("take vector", 32'h90, 32'(take_vector));
        chk("take entry", 32'h1b000, take_entry);
        warm_restart_pin <= 1'b1;
        @(posedge aclk);
        warm_restart_pin <= 1'b0;
        settle();
        chk("take class", 32'h2, 32'(take_class));
        rd(`LIPS_OFF_FWPEND, rd_val);
        chk("fw pend", 32'h10000, rd_val);
        wr(`LIPS_OFF_FWPEND, 32'h10000);
        acq(8'h90);
        wr(`LIPS_OFF_EOS, 32'h0);
        wr(`LIPS_OFF_CTRL, 32'h4);
        warm_restart_pin <= 1'b1;
        @(posedge aclk);
        warm_restart_pin <= 1'b0;
        settle();
        chk("take", 32'h0, 32'(take_valid));
        wr(`LIPS_OFF_CTRL, 32'h6);
        platform_mgmt_irq <= 1'b1;
        @(posedge aclk);
        platform_mgmt_irq <= 1'b0;
        settle();
        chk("take class", 32'h1, 32'(take_class));
        chk("take vector", 32'h0, 32'(take_vector));
        lips_peer_inst.send(8'h05, 2'd1, 8'h03);
        rd(`LIPS_OFF_FWPEND, rd_val);
        chk("fw pend", 32'h10009, rd_val);
        wr(`LIPS_OFF_FWPEND, 32'h10009);
        rd(`LIPS_OFF_FWPEND, rd_val);
        chk("fw pend", 32'h0, rd_val);
        wr(`LIPS_OFF_CTRL, 32'h1);
        wr(`LIPS_OFF_PIN0, 32'h150);
        wr(`LIPS_OFF_PIN1, 32'h060);
        local_irq_pin <= 2'b01;
        settle();
        rd(`LIPS_OFF_STATUS, rd_val);
        chk("status", 32'h50, 32'(rd_val[7:0]));
        local_irq_pin <= 2'b10;
        @(posedge aclk);
        local_irq_pin <= 2'b00;
        settle();
        rd(`LIPS_OFF_STATUS, rd_val);
        chk("status", 32'h60, 32'(rd_val[7:0]));
        acq(8'h60);
        wr(`LIPS_OFF_EOS, 32'h0);
        acq(8'h0f);
        wr(`LIPS_OFF_SRCVEC, 32'h00706050);
        {timer_evt, perfmon_evt, cmc_evt} <= 3'b111;
        @(posedge aclk);
        {timer_evt, perfmon_evt, cmc_evt} <= 3'b000;
        for (int i = 7; i > 4; i--)
        begin
            acq({i[3:0], 4'h0});
            wr(`LIPS_OFF_EOS, 32'h0);
        end
        wr(`LIPS_OFF_XCPU, 32'h0922);
        chk("xcpu target", 32'h9, 32'(cross_cpu_irq_target));
        chk("xcpu vector", 32'h22, 32'(cross_cpu_irq_vector));
        foreach (eidx[k])
        begin
            wr(`LIPS_OFF_ENTRY, eidx[k]);
            rd(`LIPS_OFF_ENTRY, rd_val);
            chk("entry", eexp[k], rd_val);
        end
        report_and_stop();
    end
endmodule : testbench
